// [sar_readout_defs.svh]
// constants for the serial result readout of the sar converter
// assumes inclusion by bare name from the design and bench files
`ifndef SAR_READOUT_DEFS_SVH
`define SAR_READOUT_DEFS_SVH
`define RESULT_BITS        18
`define CONV_TIME_NS       527
`define CLK_PERIOD_NS      25
// longest conversion time rounds down to whole cycles
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RESULT_RESET       18'h00000
`endif

// [sar_readout_pkg.sv]
// types shared by the serial result readout files
// assumes sar_readout_defs.svh is on the include path
package sar_readout_pkg;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01
	} conv_state_t;
	typedef logic [17:0] result_t;
endpackage

// [word_buf_if.sv]
// valid/ready handshake carrying one result word between modules
// assumes a single clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface word_buf_if;
	logic          valid;
	logic          ready;
	logic [17:0]   data;
	modport source
	(
		output valid,
		output data,
		input  ready
	);
	modport sink
	(
		input  valid,
		input  data,
		output ready
	);
endinterface
`default_nettype wire

// [result_buffer.sv]
// two-entry buffer that holds converted results until the shifter loads
// assumes core_clk domain, clock enable freezes all state
`timescale 1ns/10ps
`default_nettype none
module result_buffer
#(
	parameter int WIDTH = 18,
	parameter int DEPTH = 2
)
(
	input  wire logic  core_clk,
	input  wire logic  reset,
	input  wire logic  clk_en,
	word_buf_if.sink   in_side,
	word_buf_if.source out_side
);
	initial
	begin
		if (DEPTH != 2 || WIDTH != 18)
			$error("result_buffer serves two 18-bit entries");
	end

	logic [WIDTH-1:0] slot [DEPTH];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	wire              push = in_side.valid && in_side.ready;
	wire              pop  = out_side.valid && out_side.ready;

	// honest full and empty
	assign in_side.ready  = (count != 2'h2);
	assign out_side.valid = (count != 2'h0);
	assign out_side.data  = slot[rd_ptr];

	// storage and pointers
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			slot[0] <= '0;
			slot[1] <= '0;
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
			count   <= 2'h0;
		end
		else if (clk_en)
		begin
			if (push)
			begin
				slot[wr_ptr] <= in_side.data;
				wr_ptr       <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	count_range_a: assert property (@(posedge core_clk) disable iff (reset)
		count <= 2'h2)
		else $error("buffer count out of range");
endmodule
`default_nettype wire

// [sar_adc_serial_readout.sv]
// serial result readout of an 18-bit sar converter, device side
// assumes shift clock, convert start and select arrive asynchronously;
// result_data comes from the converter core on core_clk
`timescale 1ns/10ps
`default_nettype none
`include "sar_readout_defs.svh"

// Summary of operation
// - select low puts msb out three core clocks later
// - daisy mode keeps output always driven
// - daisy mode select becomes serial input
// - upstream msb emerges after 18 shifts
// - serial input captured on each rising edge
// - normal mode: select high floats output
// - output changes on rising shift edge
// - start edge begins unrestartable busy conversion
// - msb present when busy falls
module sar_adc_serial_readout
	import sar_readout_pkg::*;
#(
	parameter int BITS        = `RESULT_BITS,
	parameter int CONV_CYCLES = `CONV_CYCLES
)
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   clk_en,
	input  wire logic                   convert_start,
	input  wire logic                   shift_clk,
	input  wire logic                   read_select_or_cascade_in,
	input  wire logic                   chain_mode,
	input  wire sar_readout_pkg::result_t result_data,
	output logic                        busy,
	output logic                        serial_out,
	output logic                        serial_out_en
);
	import sar_readout_pkg::*;

	initial
	begin
		if (BITS != 18 || CONV_CYCLES < 2 || CONV_CYCLES > 65535)
			$error("readout serves 18 bits and 2 to 65535 cycles");
	end

	// two-flop synchronisers for all outside pins
	logic [1:0] cnv_s;
	logic [1:0] sck_s;
	logic [1:0] sel_s;
	logic [1:0] mode_s;
	logic       cnv_d;
	logic       sck_d;
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			cnv_s  <= 2'h0;
			sck_s  <= 2'h0;
			sel_s  <= 2'h3;
			mode_s <= 2'h0;
			cnv_d  <= 1'b0;
			sck_d  <= 1'b0;
		end
		else if (clk_en)
		begin
			cnv_s  <= {cnv_s[0], convert_start};
			sck_s  <= {sck_s[0], shift_clk};
			sel_s  <= {sel_s[0], read_select_or_cascade_in};
			mode_s <= {mode_s[0], chain_mode};
			cnv_d  <= cnv_s[1];
			sck_d  <= sck_s[1];
		end
	end

	// decoded edges and levels
	wire cnv_rise  = cnv_s[1] && !cnv_d;
	wire sck_rise  = sck_s[1] && !sck_d;
	wire daisy     = mode_s[1];
	wire sel_level = sel_s[1];

	// conversion timer
	conv_state_t state;
	conv_state_t next_state;
	logic [15:0] conv_cnt;
	word_buf_if  to_buf ();
	word_buf_if  from_buf ();
	wire conv_done = (state == ST_CONV) && (conv_cnt == 16'h0001);
	wire push_word = (state == ST_CONV) && (conv_cnt == 16'h0002);
	wire start_ok  = cnv_rise && (state == ST_IDLE);

	always_comb
	begin
		case (state)
			ST_IDLE: next_state = start_ok ? ST_CONV : ST_IDLE;
			ST_CONV: next_state = conv_done ? ST_IDLE : ST_CONV;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state    <= ST_IDLE;
			conv_cnt <= 16'h0000;
		end
		else if (clk_en)
		begin
			state <= next_state;
			if (start_ok)
				conv_cnt <= 16'(CONV_CYCLES);
			else if (state == ST_CONV && conv_cnt != 16'h0001)
				conv_cnt <= conv_cnt - 16'h0001;
		end
	end

	// result enters the buffer a cycle early so the msb is out as busy falls
	assign to_buf.valid = push_word;
	assign to_buf.data  = result_data;

	result_buffer #(
		.WIDTH (BITS),
		.DEPTH (2)
	) u_buf (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.in_side  (to_buf.sink),
		.out_side (from_buf.source)
	);

	// shifter takes a word whenever the next state is idle and a word waits
	logic [17:0] shreg;
	wire         busy_next_hi = (next_state == ST_CONV);
	wire         load = from_buf.valid && !busy_next_hi;
	assign from_buf.ready = !busy_next_hi;

	// busy mirrors the conversion state
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			busy <= 1'b0;
		else if (clk_en)
			busy <= busy_next_hi;
	end

	// shift register: load at conversion end, shift on rising shift clock
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			shreg    <= `RESULT_RESET;
		end
		else if (clk_en)
		begin
			if (load)
			begin
				shreg    <= from_buf.data;
			end
			else if (sck_rise)
			begin
				// daisy takes the cascade bit in behind
				shreg    <= {shreg[16:0], daisy ? sel_level : 1'b0};
			end
		end
	end

	// output pin: msb straight out, enable by mode and select
	wire next_en = daisy ? 1'b1 : !sel_level;
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			serial_out    <= 1'b0;
			serial_out_en <= 1'b0;
		end
		else if (clk_en)
		begin
			serial_out    <= load ? from_buf.data[17] : shreg[17];
			serial_out_en <= next_en;
		end
	end

	daisy_driven_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && daisy |=> serial_out_en)
		else $error("daisy mode output not driven");
	select_float_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && !daisy && sel_level |=> !serial_out_en)
		else $error("output driven while deselected");
	select_drive_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && !daisy && !sel_level |=> serial_out_en)
		else $error("output floats while selected");
	no_restart_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && state == ST_CONV && cnv_rise && !conv_done
		|=> state == ST_CONV && conv_cnt == $past(conv_cnt) - 16'h0001)
		else $error("conversion restarted");
	busy_start_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && start_ok |=> busy)
		else $error("busy did not rise on start");
	msb_load_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && load |=> shreg == $past(from_buf.data))
		else $error("result not loaded");
	shift_in_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && !load && sck_rise && daisy
		|=> shreg[0] == $past(sel_level)
			&& shreg[17:1] == $past(shreg[16:0]))
		else $error("cascade bit not shifted in");
	out_follow_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && !load |=> serial_out == $past(shreg[17]))
		else $error("output does not follow shift msb");
	// core result must already be on the pin at the busy fall
	msb_at_fall_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && conv_done
		|=> !busy && serial_out == $past(result_data[17], 2))
		else $error("msb missing as busy falls");
	zero_fill_a: assert property (@(posedge core_clk) disable iff (reset)
		clk_en && !load && sck_rise && !daisy
		|=> shreg == {$past(shreg[16:0]), 1'b0})
		else $error("normal mode shift not zero filled");
endmodule
`default_nettype wire

// [sar_host_model.sv]
// host controller model: drives start, shift clock and select pins
// assumes the device samples every pin on core_clk
`timescale 1ns/10ps
`default_nettype none
module sar_host_model
(
	input  wire logic core_clk,
	input  wire logic busy,
	input  wire logic serial_out,
	output logic      convert_start,
	output logic      shift_clk,
	output logic      read_select_or_cascade_in
);
	// pins at rest: start low, shift clock still, select high
	initial
	begin
		convert_start = 1'b0;
		shift_clk = 1'b0;
		read_select_or_cascade_in = 1'b1;
	end
	// one select change at a time so only one device drives the line
	task automatic sel(input logic v);
		@(negedge core_clk);
		read_select_or_cascade_in = v;
	endtask
	// start a conversion, count busy cycles, optionally retrigger mid-way
	task automatic convert(input bit again, output int w);
		w = 0;
		@(negedge core_clk);
		convert_start = 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge core_clk);
			if (busy === 1'b1)
				w++;
			if (i == 3)
				convert_start = 1'b0;
			if (i == 7)
				convert_start = again;
		end
		convert_start = 1'b0;
	endtask
	// n shift clocks of 200 ns, sample before each rise, feed cascade bit
	task automatic shift(input int n, input logic [35:0] cin,
		output logic [35:0] got);
		got = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			got[i] = serial_out;
			read_select_or_cascade_in = cin[i];
			repeat (2) @(negedge core_clk);
			shift_clk = 1'b1;
			repeat (4) @(negedge core_clk);
			shift_clk = 1'b0;
			repeat (2) @(negedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// [sar_adc_serial_readout_tb_top.sv]
// self-checking bench for the serial result readout
// assumes the host model drives all pins at the falling clock edge
`timescale 1ns/10ps
`default_nettype none
`include "sar_readout_defs.svh"
module sar_adc_serial_readout_tb_top;
	import sar_readout_pkg::*;
	typedef struct packed {result_t res; logic msb;} row_t;
	logic        core_clk = 1'b0;
	logic        reset;
	logic        clk_en;
	wire         line_level;
	logic        chain_mode;
	logic        busy;
	logic        serial_out;
	logic        serial_out_en;
	logic        convert_start;
	logic        shift_clk;
	logic        read_select_or_cascade_in;
	result_t     result_data;
	logic [35:0] got;
	int          fail_count;
	int          checks;
	int          cyc;
	int          w;
	row_t        rows [4] = '{'{18'h3FFFF, 1'b1}, '{18'h00001, 1'b0},
		'{18'h2AAAA, 1'b1}, '{18'h15555, 1'b0}};

	sar_adc_serial_readout u_sar_adc_serial_readout (
		.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.convert_start(convert_start), .shift_clk(shift_clk),
		.read_select_or_cascade_in(read_select_or_cascade_in),
		.chain_mode(chain_mode), .result_data(result_data),
		.busy(busy), .serial_out(serial_out),
		.serial_out_en(serial_out_en));
	sar_host_model u_sar_host_model (
		.core_clk(core_clk), .busy(busy), .serial_out(line_level),
		.convert_start(convert_start), .shift_clk(shift_clk),
		.read_select_or_cascade_in(read_select_or_cascade_in));
	// a released line shows the wrong level so a stray read is caught
	assign line_level = serial_out_en ? serial_out : ~serial_out;

	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;
	// compare and count
	task automatic chk(input string nm, input logic [35:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic test_done();
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			test_done();
		end
	end
	// reset, table of normal reads, then awkward cases
	initial
	begin
		reset = 1'b1;
		chain_mode = 1'b0;
		clk_en = 1'b1;
		result_data = '0;
		fail_count = 0;
		checks = 0;
		cyc = 0;
		repeat (2) @(negedge core_clk);
		chk("reset_out", {busy, serial_out, serial_out_en}, 3'h0);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
		foreach (rows[i])
		begin
			result_data = rows[i].res;
			u_sar_host_model.sel(1'b0);
			u_sar_host_model.convert(1'b0, w);
			chk("busy_len", w, `CONV_CYCLES);
			chk("msb_at_end", {serial_out_en, serial_out},
				{1'b1, rows[i].msb});
			u_sar_host_model.shift(18, 36'h0, got);
			chk("word", got[17:0], rows[i].res);
			u_sar_host_model.sel(1'b1);
			repeat (5) @(negedge core_clk);
			chk("float", serial_out_en, 1'b0);
		end
		// restart attempt during busy, read selected afterwards
		result_data = 18'h20000;
		u_sar_host_model.convert(1'b1, w);
		chk("no_restart", w, `CONV_CYCLES);
		chk("float_idle", serial_out_en, 1'b0);
		u_sar_host_model.sel(1'b0);
		repeat (5) @(negedge core_clk);
		chk("select_msb", {serial_out_en, serial_out}, 2'h3);
		// clock enable low freezes the pin logic, release lets it float
		clk_en = 1'b0;
		u_sar_host_model.sel(1'b1);
		repeat (5) @(negedge core_clk);
		chk("frozen_en", serial_out_en, 1'b1);
		clk_en = 1'b1;
		repeat (5) @(negedge core_clk);
		chk("float_thaw", serial_out_en, 1'b0);
		// two-deep cascade with select high: own word then upstream word
		chain_mode = 1'b1;
		result_data = 18'h0F0F3;
		u_sar_host_model.convert(1'b0, w);
		chk("chain_drive", serial_out_en, 1'b1);
		u_sar_host_model.shift(36, {18'h3C3C5, 18'h0}, got);
		chk("chain_word", got, {18'h0F0F3, 18'h3C3C5});
		// reset in mid-run clears outputs, daisy drive comes back
		reset = 1'b1;
		@(negedge core_clk);
		chk("reset_mid", {busy, serial_out, serial_out_en}, 3'h0);
		reset = 1'b0;
		repeat (5) @(negedge core_clk);
		chk("chain_again", serial_out_en, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
